// *** tak_ctrl.sv ***
`timescale 1ns/1ps
module tak_ctrl (
  input wire logic clk, // 200 MHz system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic ce, // clock enable, freezes state
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address or write to a read-only register
  input wire logic [11:0] adc_data, // converter result
  output logic conv_start, // start conversion pulse
  output logic [3:0] mux_sel, // input mux selection
  output logic x_pos_drv, // x+ driver on
  output logic x_neg_drv, // x- driver on
  output logic y_pos_drv, // y+ driver on
  output logic y_neg_drv, // y- driver on
  output logic pen_pullup_en, // x+ pullup for touch detect
  input wire logic pen_sense_i, // x+ level, low when touched
  output logic ref_on, // internal reference powered
  output logic ref_source_sel, // 1 external reference
  output logic ref_level_sel, // 1 selects 2.5 V
  output logic [7:0] dac_code, // DAC code
  input wire logic [3:0] row_i, // row pin level
  output logic [3:0] row_o, // row pin drive value
  output logic [3:0] row_oe, // row pin output enable
  input wire logic [3:0] col_i, // column pin level
  output logic [3:0] col_o, // column pin drive value
  output logic [3:0] col_oe, // column pin output enable
  output logic busy_n, // busy, active low
  output logic touch_irq_n, // pen interrupt, active low
  output logic keypress_irq_n // key interrupt, active low
);

  tak_pkg::tak_main_st_t r;
  tak_pkg::tak_main_st_t n;
  logic osc_tick;
  logic wr;
  logic rd;
  logic [31:0] rd_val;
  logic rd_ok;
  logic [15:0] mon_keys;
  logic [4:0] key_count;
  logic gpio_allowed;
  logic [7:0] gpio_eff;
  logic [3:0] col_drive;
  logic [15:0] kp_keys;
  logic kp_valid;
  logic kp_busy;
  logic [15:0] eff_keys;
  logic scan_busy;
  logic needs_ref;

  // count monitored keys in a mask
  function automatic logic [4:0] popcount16(input logic [15:0] v);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < 16; i++) begin
      c = c + {4'h0, v[i]};
    end
    popcount16 = c;
  endfunction

  // reference-using conversions: battery, aux, temperature
  function automatic logic uses_ref(input logic [3:0] s);
    uses_ref = (s >= tak_pkg::SEL_BAT1) && (s <= tak_pkg::SEL_TEMP);
  endfunction

  // trim a result to the selected resolution
  function automatic logic [11:0] res_trim(input logic [11:0] d,
                                           input logic [1:0] s);
    case (s)
      2'h0: res_trim = {4'h0, d[11:4]};
      2'h1: res_trim = {2'h0, d[11:2]};
      default: res_trim = d;
    endcase
  endfunction

  // key monitored unless its own bit or its column is masked
  always_comb begin
    for (int k = 0; k < 16; k++) begin
      mon_keys[k] = !r.key_mask[k] && !r.col_mask[k/4];
    end
  end

  assign key_count = popcount16(mon_keys);
  assign gpio_allowed = key_count <= tak_pkg::GPIO_MAX_KEYS;
  assign gpio_eff = gpio_allowed ? r.gpio_sel : 8'h00;
  assign eff_keys = kp_keys & mon_keys;
  assign scan_busy = r.scan != tak_pkg::SC_IDLE;
  assign needs_ref = uses_ref(r.cur_sel);

  // apb strobes in the access phase
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;

  // read value decode
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (paddr == tak_pkg::ADR_ADC_CTRL) begin
      rd_val = {20'h00000, r.adc};
    end else if (paddr == tak_pkg::ADR_DAC) begin
      rd_val = {24'h000000, r.dac};
    end else if (paddr == tak_pkg::ADR_KEY_CTRL) begin
      rd_val = {28'h0000000, r.kctl};
    end else if (paddr == tak_pkg::ADR_KEY_MASK) begin
      rd_val = {16'h0000, r.key_mask};
    end else if (paddr == tak_pkg::ADR_COL_MASK) begin
      rd_val = {28'h0000000, r.col_mask};
    end else if (paddr == tak_pkg::ADR_KEY_PEND) begin
      rd_val = {16'h0000, r.pending};
    end else if (paddr == tak_pkg::ADR_KEY_SCAN) begin
      rd_val = {16'h0000, r.scan_res};
    end else if (paddr == tak_pkg::ADR_GPIO_SEL) begin
      rd_val = {24'h000000, r.gpio_sel};
    end else if (paddr == tak_pkg::ADR_GPIO_OUT) begin
      rd_val = {16'h0000, r.gpio_dir, r.gpio_out};
    end else if (paddr == tak_pkg::ADR_GPIO_IN) begin
      rd_val = {24'h000000, r.pins[7:0]};
    end else if (paddr == tak_pkg::ADR_STATUS) begin
      rd_val = {26'h0000000, gpio_allowed, !r.pins[8], kp_busy,
                scan_busy, ref_on, !busy_n};
    end else if (paddr == tak_pkg::ADR_RESULT) begin
      rd_val = {20'h00000, r.result};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // next state of the whole block
  always_comb begin
    n = r;
    n.conv_start = 1'b0;
    // three-stage pin synchronisers, accept when stages two and three agree
    n.sync[0] = {pen_sense_i, col_i, row_i};
    n.sync[1] = r.sync[0];
    n.sync[2] = r.sync[1];
    for (int i = 0; i < 9; i++) begin
      if (r.sync[1][i] == r.sync[2][i]) begin
        n.pins[i] = r.sync[2][i];
      end
    end
    // internal 10 MHz oscillator from the system clock
    n.osc_div = osc_tick ? 5'h00 : r.osc_div + 5'h01;
    // setup phase: register read data and error
    if (psel && !penable) begin
      n.prdata = rd_val;
      n.pslverr = !rd_ok || (pwrite && (paddr == tak_pkg::ADR_KEY_PEND ||
                  paddr == tak_pkg::ADR_KEY_SCAN ||
                  paddr == tak_pkg::ADR_GPIO_IN ||
                  paddr == tak_pkg::ADR_STATUS ||
                  paddr == tak_pkg::ADR_RESULT));
    end
    // pending keys: read clears, a new press in the same cycle wins
    if (rd && paddr == tak_pkg::ADR_KEY_PEND) begin
      n.pending = 16'h0000;
    end
    if (kp_valid) begin
      n.pending = n.pending | (eff_keys & ~r.scan_res);
      n.scan_res = eff_keys;
    end
    if (!r.kctl.key_detect_en) begin
      n.scan_res = 16'h0000;
    end
    // register writes
    if (wr) begin
      if (paddr == tak_pkg::ADR_ADC_CTRL) begin
        n.adc = pwdata[11:0];
      end else if (paddr == tak_pkg::ADR_DAC) begin
        n.dac = pwdata[7:0];
      end else if (paddr == tak_pkg::ADR_KEY_CTRL) begin
        n.kctl = pwdata[3:0];
      end else if (paddr == tak_pkg::ADR_KEY_MASK) begin
        n.key_mask = pwdata[15:0];
      end else if (paddr == tak_pkg::ADR_COL_MASK) begin
        n.col_mask = pwdata[3:0];
      end else if (paddr == tak_pkg::ADR_GPIO_SEL) begin
        n.gpio_sel = pwdata[7:0];
      end else if (paddr == tak_pkg::ADR_GPIO_OUT) begin
        n.gpio_out = pwdata[7:0];
        n.gpio_dir = pwdata[15:8];
      end
    end
    // scan sequencer, timed in oscillator ticks
    case (r.scan)
      tak_pkg::SC_IDLE: begin
        // zero select bits start no scan, the write only loads the control register
        if (wr && paddr == tak_pkg::ADR_ADC_CTRL && pwdata[3:0] != 4'h0) begin
          n.cur_sel = pwdata[3:0];
          if (uses_ref(pwdata[3:0]) && pwdata[5:4] == 2'b00) begin
            n.scan = tak_pkg::SC_REF_UP;
            n.cnt = tak_pkg::ref_ticks(pwdata[8:7]) - 10'h001;
          end else begin
            n.scan = tak_pkg::SC_SETTLE;
            n.cnt = tak_pkg::PANEL_TICKS - 10'h001;
          end
        end
      end
      tak_pkg::SC_REF_UP: begin
        if (osc_tick) begin
          if (r.cnt != 10'h000) begin
            n.cnt = r.cnt - 10'h001;
          end else begin
            n.scan = tak_pkg::SC_SETTLE;
            n.cnt = tak_pkg::PANEL_TICKS - 10'h001;
          end
        end
      end
      tak_pkg::SC_SETTLE: begin
        if (osc_tick) begin
          if (r.cnt != 10'h000) begin
            n.cnt = r.cnt - 10'h001;
          end else begin
            n.scan = tak_pkg::SC_ACQ;
            n.cnt = tak_pkg::acq_ticks(r.adc.acq_sel) - 10'h001;
          end
        end
      end
      tak_pkg::SC_ACQ: begin
        if (osc_tick) begin
          if (r.cnt != 10'h000) begin
            n.cnt = r.cnt - 10'h001;
          end else begin
            n.scan = tak_pkg::SC_CONV;
            n.conv_start = 1'b1;
            n.cnt = tak_pkg::conv_ticks(r.adc.res_sel) - 10'h001;
          end
        end
      end
      tak_pkg::SC_CONV: begin
        if (osc_tick) begin
          if (r.cnt != 10'h000) begin
            n.cnt = r.cnt - 10'h001;
          end else begin
            n.scan = tak_pkg::SC_IDLE;
            n.result = res_trim(adc_data, r.adc.res_sel);
          end
        end
      end
      default: begin
        n.scan = tak_pkg::SC_IDLE;
      end
    endcase
  end

  // state register, cleared on reset except DAC midscale
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
      r.dac <= tak_pkg::DAC_RESET;
    end else if (ce) begin
      r <= n;
    end
  end

  assign osc_tick = r.osc_div == tak_pkg::OSC_DIV_LAST;

  tak_keypad u_keypad (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .osc_tick(osc_tick),
    .enable(r.kctl.key_detect_en),
    .debounce_sel(r.kctl.debounce_sel),
    .rows(r.pins[3:0] & ~gpio_eff[3:0]),
    .col_skip(r.col_mask | gpio_eff[7:4]),
    .col_drive(col_drive),
    .keys(kp_keys),
    .keys_valid(kp_valid),
    .busy(kp_busy)
  );

  // apb answer with no wait states
  assign pready = 1'b1;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr && psel && penable;

  // reference control
  assign ref_on = !r.adc.ref_source_sel && (r.adc.ref_power_keep ||
                  (scan_busy && needs_ref));
  assign ref_source_sel = r.adc.ref_source_sel;
  assign ref_level_sel = r.adc.ref_level_sel;
  // unsigned code, one step is reference over 256
  assign dac_code = r.dac;

  // panel drivers and sense selection
  assign conv_start = r.conv_start;
  assign mux_sel = scan_busy ? r.cur_sel : 4'h0;
  assign y_pos_drv = scan_busy && r.cur_sel == tak_pkg::SEL_Y;
  assign y_neg_drv = (scan_busy && r.cur_sel == tak_pkg::SEL_Y) ||
                     (!scan_busy && r.adc.touch_en);
  assign x_pos_drv = scan_busy && r.cur_sel == tak_pkg::SEL_X;
  assign x_neg_drv = scan_busy && r.cur_sel == tak_pkg::SEL_X;
  assign pen_pullup_en = !scan_busy && r.adc.touch_en;

  // keypad and GPIO pins
  assign row_o = r.gpio_out[3:0];
  assign row_oe = gpio_eff[3:0] & r.gpio_dir[3:0];
  assign col_o = (r.gpio_out[7:4] & gpio_eff[7:4]) | ~gpio_eff[7:4];
  assign col_oe = (gpio_eff[7:4] & r.gpio_dir[7:4]) | col_drive;

  // busy and interrupt outputs
  assign busy_n = !(scan_busy || kp_busy);
  assign touch_irq_n = !(r.adc.touch_en && !scan_busy && !r.pins[8]);
  assign keypress_irq_n = !(r.kctl.key_irq_en && |r.pending);

endmodule

// *** tak_pkg.sv ***
package tak_pkg;

  // clock and internal oscillator rates
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned OSC_MHZ = 10;
  localparam logic [4:0] OSC_DIV_LAST = 5'(CLK_MHZ / OSC_MHZ - 1);

  // acquisition times in ns, as programmed
  localparam int unsigned ACQ_SHORT_NS = 1500;
  localparam int unsigned ACQ_MID_NS = 5000;
  localparam int unsigned ACQ_LONG_NS = 95000;
  // reference power-up wait per resolution, in ns
  localparam int unsigned REF_UP8_NS = 10000;
  localparam int unsigned REF_UP10_NS = 15000;
  localparam int unsigned REF_UP12_NS = 20000;
  // panel and keypad column settling, in ns
  localparam int unsigned PANEL_SETTLE_NS = 1000;
  localparam int unsigned KEY_SETTLE_NS = 1000;

  // least times rounded up to whole oscillator ticks
  localparam logic [9:0] ACQ_SHORT_TICKS = 10'((ACQ_SHORT_NS*OSC_MHZ+999)/1000);
  localparam logic [9:0] ACQ_MID_TICKS = 10'((ACQ_MID_NS*OSC_MHZ+999)/1000);
  localparam logic [9:0] ACQ_LONG_TICKS = 10'((ACQ_LONG_NS*OSC_MHZ+999)/1000);
  localparam logic [9:0] REF_UP8_TICKS = 10'((REF_UP8_NS*OSC_MHZ+999)/1000);
  localparam logic [9:0] REF_UP10_TICKS = 10'((REF_UP10_NS*OSC_MHZ+999)/1000);
  localparam logic [9:0] REF_UP12_TICKS = 10'((REF_UP12_NS*OSC_MHZ+999)/1000);
  localparam logic [9:0] PANEL_TICKS =
    10'((PANEL_SETTLE_NS*OSC_MHZ+999)/1000);
  localparam logic [4:0] KEY_TICKS = 5'((KEY_SETTLE_NS*OSC_MHZ+999)/1000);
  // conversion length per resolution, in ticks
  localparam logic [9:0] CONV8_TICKS = 10'h009;
  localparam logic [9:0] CONV10_TICKS = 10'h00B;
  localparam logic [9:0] CONV12_TICKS = 10'h00D;

  // register byte offsets
  localparam logic [7:0] ADR_ADC_CTRL = 8'h00;
  localparam logic [7:0] ADR_DAC = 8'h04;
  localparam logic [7:0] ADR_KEY_CTRL = 8'h08;
  localparam logic [7:0] ADR_KEY_MASK = 8'h0C;
  localparam logic [7:0] ADR_COL_MASK = 8'h10;
  localparam logic [7:0] ADR_KEY_PEND = 8'h14;
  localparam logic [7:0] ADR_KEY_SCAN = 8'h18;
  localparam logic [7:0] ADR_GPIO_SEL = 8'h1C;
  localparam logic [7:0] ADR_GPIO_OUT = 8'h20;
  localparam logic [7:0] ADR_GPIO_IN = 8'h24;
  localparam logic [7:0] ADR_STATUS = 8'h28;
  localparam logic [7:0] ADR_RESULT = 8'h2C;

  // reset values and limits
  localparam logic [7:0] DAC_RESET = 8'h80;
  localparam logic [4:0] GPIO_MAX_KEYS = 5'h0C;

  // conversion select codes
  localparam logic [3:0] SEL_X = 4'h1;
  localparam logic [3:0] SEL_Y = 4'h2;
  localparam logic [3:0] SEL_BAT1 = 4'h3;
  localparam logic [3:0] SEL_TEMP = 4'h7;

  typedef struct packed {
    logic touch_en;
    logic [1:0] acq_sel;
    logic [1:0] res_sel;
    logic ref_level_sel;
    logic ref_power_keep;
    logic ref_source_sel;
    logic [3:0] conv_select_bits;
  } tak_adc_ctrl_t;

  typedef struct packed {
    logic [1:0] debounce_sel;
    logic key_irq_en;
    logic key_detect_en;
  } tak_key_ctrl_t;

  typedef enum logic [2:0] {
    SC_IDLE, SC_REF_UP, SC_SETTLE, SC_ACQ, SC_CONV
  } tak_scan_t;

  typedef struct packed {
    logic [2:0][8:0] sync;
    logic [8:0] pins;
    logic [4:0] osc_div;
    tak_adc_ctrl_t adc;
    logic [7:0] dac;
    tak_key_ctrl_t kctl;
    logic [15:0] key_mask;
    logic [3:0] col_mask;
    logic [7:0] gpio_sel;
    logic [7:0] gpio_dir;
    logic [7:0] gpio_out;
    logic [15:0] pending;
    logic [15:0] scan_res;
    logic [11:0] result;
    tak_scan_t scan;
    logic [9:0] cnt;
    logic [3:0] cur_sel;
    logic conv_start;
    logic [31:0] prdata;
    logic pslverr;
  } tak_main_st_t;

  typedef struct packed {
    logic [1:0] col;
    logic [4:0] cnt;
    logic [15:0] sample;
    logic [15:0] last;
    logic [4:0] stable;
    logic [15:0] result;
    logic valid;
  } tak_kp_st_t;

  function automatic logic [9:0] acq_ticks(input logic [1:0] s);
    case (s)
      2'h0: acq_ticks = ACQ_SHORT_TICKS;
      2'h1: acq_ticks = ACQ_MID_TICKS;
      default: acq_ticks = ACQ_LONG_TICKS;
    endcase
  endfunction

  function automatic logic [9:0] ref_ticks(input logic [1:0] s);
    case (s)
      2'h0: ref_ticks = REF_UP8_TICKS;
      2'h1: ref_ticks = REF_UP10_TICKS;
      default: ref_ticks = REF_UP12_TICKS;
    endcase
  endfunction

  function automatic logic [9:0] conv_ticks(input logic [1:0] s);
    case (s)
      2'h0: conv_ticks = CONV8_TICKS;
      2'h1: conv_ticks = CONV10_TICKS;
      default: conv_ticks = CONV12_TICKS;
    endcase
  endfunction

  function automatic logic [4:0] debounce_scans(input logic [1:0] s);
    case (s)
      2'h0: debounce_scans = 5'h02;
      2'h1: debounce_scans = 5'h04;
      2'h2: debounce_scans = 5'h08;
      default: debounce_scans = 5'h10;
    endcase
  endfunction

endpackage

// *** tak_keypad.sv ***
`timescale 1ns/1ps
// column-by-column matrix scan with consecutive-scan debounce
module tak_keypad (
  input wire logic clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic osc_tick, // internal oscillator tick
  input wire logic enable, // key detection on
  input wire logic [1:0] debounce_sel, // debounce length select
  input wire logic [3:0] rows, // synchronised row levels
  input wire logic [3:0] col_skip, // columns left out of the scan
  output logic [3:0] col_drive, // column driven high
  output logic [15:0] keys, // debounced raw key pattern
  output logic keys_valid, // new debounced pattern
  output logic busy // debounce in progress
);

  tak_pkg::tak_kp_st_t r;
  tak_pkg::tak_kp_st_t n;
  logic [15:0] vec;

  // next state: settle, sample a column, compare full scans
  always_comb begin
    n = r;
    n.valid = 1'b0;
    vec = r.sample;
    vec[{r.col, 2'b00} +: 4] = col_skip[r.col] ? 4'h0 : rows;
    if (!enable) begin
      n = '0;
    end else if (osc_tick) begin
      if (r.cnt != 5'h00) begin
        n.cnt = r.cnt - 5'h01;
      end else begin
        n.cnt = tak_pkg::KEY_TICKS - 5'h01;
        n.sample = vec;
        n.col = r.col + 2'h1;
        if (r.col == 2'h3) begin
          n.last = vec;
          if (vec != r.last) begin
            n.stable = 5'h00;
          end else if (r.stable != tak_pkg::debounce_scans(debounce_sel)) begin
            n.stable = r.stable + 5'h01;
            if (r.stable + 5'h01 == tak_pkg::debounce_scans(debounce_sel)) begin
              n.result = vec;
              n.valid = 1'b1;
            end
          end
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  // one column at a time, four rows each
  assign col_drive = enable ? ((4'h1 << r.col) & ~col_skip) : 4'h0;
  assign keys = r.result;
  assign keys_valid = r.valid;
  assign busy = enable && (r.stable != 5'h00) && (r.last != r.result);

endmodule

// *** tak_ctrl_assertions.sv ***
`timescale 1ns/1ps
module tak_ctrl_assertions (
  input wire logic clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic conv_start, // conversion start
  input wire logic [3:0] mux_sel, // mux select
  input wire logic x_pos_drv, // x+ driver
  input wire logic x_neg_drv, // x- driver
  input wire logic y_pos_drv, // y+ driver
  input wire logic y_neg_drv, // y- driver
  input wire logic ref_on, // reference powered
  input wire logic ref_source_sel, // external reference
  input wire logic [7:0] dac_code, // dac code
  input wire logic busy_n // busy, active low
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic keep_r;
  logic acc;
  logic dac_wr;
  // completed apb access
  assign acc = psel && penable && ce;
  assign dac_wr = acc && pwrite && paddr == tak_pkg::ADR_DAC;
  // shadow of the reference keep bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      keep_r <= 1'b0;
    end else if (acc && pwrite && paddr == tak_pkg::ADR_ADC_CTRL) begin
      keep_r <= pwdata[5];
    end
  end
  property p_rst;
    rst_n && !$past(rst_n) |-> dac_code == tak_pkg::DAC_RESET && busy_n
      && !ref_on;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_dac_hold;
    !dac_wr |=> $stable(dac_code);
  endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("dac moved");
  property p_dac_wr;
    dac_wr |=> dac_code == $past(pwdata[7:0]);
  endproperty
  a_dac_wr: assert property (p_dac_wr) else $error("dac not loaded");
  property p_vert;
    mux_sel == tak_pkg::SEL_Y |-> y_pos_drv && y_neg_drv && !x_pos_drv
      && !x_neg_drv;
  endproperty
  a_vert: assert property (p_vert) else $error("y drivers wrong");
  property p_horiz;
    mux_sel == tak_pkg::SEL_X |-> x_pos_drv && x_neg_drv && !y_pos_drv
      && !y_neg_drv;
  endproperty
  a_horiz: assert property (p_horiz) else $error("x drivers wrong");
  property p_busy;
    mux_sel != 4'h0 |-> !busy_n;
  endproperty
  a_busy: assert property (p_busy) else $error("busy high in scan");
  property p_conv;
    conv_start |-> !busy_n ##1 !conv_start;
  endproperty
  a_conv: assert property (p_conv) else $error("conv start wrong");
  property p_auto;
    busy_n && !keep_r |-> !ref_on;
  endproperty
  a_auto: assert property (p_auto) else $error("ref on while idle");
  property p_keep;
    keep_r && !ref_source_sel |-> ref_on;
  endproperty
  a_keep: assert property (p_keep) else $error("ref off in keep");
  property p_ref_conv;
    conv_start && mux_sel >= tak_pkg::SEL_BAT1 && mux_sel <= tak_pkg::SEL_TEMP
      && !ref_source_sel |-> ref_on;
  endproperty
  a_ref_conv: assert property (p_ref_conv) else $error("ref off");
  c_y: cover property (conv_start && mux_sel == tak_pkg::SEL_Y);
  c_temp: cover property (conv_start && mux_sel == tak_pkg::SEL_TEMP);
  c_keep: cover property (keep_r && !busy_n);
endmodule
bind tak_ctrl tak_ctrl_assertions i_chk (.clk(clk), .rst_n(rst_n),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .conv_start(conv_start),
  .mux_sel(mux_sel), .x_pos_drv(x_pos_drv), .x_neg_drv(x_neg_drv),
  .y_pos_drv(y_pos_drv), .y_neg_drv(y_neg_drv), .ref_on(ref_on),
  .ref_source_sel(ref_source_sel), .dac_code(dac_code), .busy_n(busy_n));

// *** tak_panel_model.sv ***
`timescale 1ns/1ps
// keypad matrix and touch panel as seen from the pins
module tak_panel_model (
  input wire logic [3:0] col_o, // column drive value
  input wire logic [3:0] col_oe, // column drive enable
  input wire logic [15:0] pressed, // closed keys, bit col*4+row
  input wire logic touched, // panel pressed
  output logic [3:0] row_lvl, // row pin level
  output logic [3:0] col_lvl, // column pin level
  output logic pen_lvl // x+ level, low when touched
);
  // rows pulled down, lifted by a closed key on a driven column
  always_comb begin
    row_lvl = 4'h0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        if (col_oe[c] && col_o[c] && pressed[c*4+r]) begin
          row_lvl[r] = 1'b1;
        end
      end
    end
    col_lvl = col_oe & col_o;
  end
  // x+ pulled up, grounded through the panel on touch
  assign pen_lvl = !touched;
endmodule

// *** test_tak_ctrl.sv ***
`timescale 1ns/1ps
module test_tak_ctrl;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, conv_start, xp, xn, yp, yn, pen_pu, pen_s;
  logic ref_on, ref_src, ref_lvl, busy_n, tirq_n, kirq_n;
  logic [11:0] adc_data = 12'h000;
  logic [3:0] mux_sel, row_i, row_o, row_oe, col_i, col_o, col_oe;
  logic [7:0] dac_code;
  logic [15:0] pressed = 16'h0;
  logic touched = 1'b0;
  logic ce = 1'b1;
  int err_count = 0, total_checks = 0, seed = 75339;
  // system clock
  always #2.5 clk = ~clk;
  tak_ctrl i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_data(adc_data), .conv_start(conv_start), .mux_sel(mux_sel),
    .x_pos_drv(xp), .x_neg_drv(xn), .y_pos_drv(yp), .y_neg_drv(yn),
    .pen_pullup_en(pen_pu), .pen_sense_i(pen_s), .ref_on(ref_on),
    .ref_source_sel(ref_src), .ref_level_sel(ref_lvl),
    .dac_code(dac_code), .row_i(row_i), .row_o(row_o), .row_oe(row_oe),
    .col_i(col_i), .col_o(col_o), .col_oe(col_oe), .busy_n(busy_n),
    .touch_irq_n(tirq_n), .keypress_irq_n(kirq_n));
  tak_panel_model i_panel (.col_o(col_o), .col_oe(col_oe),
    .pressed(pressed), .touched(touched), .row_lvl(row_i),
    .col_lvl(col_i), .pen_lvl(pen_s));
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_near(input string what, input int exp, input int got);
    total_checks++;
    if (got < exp - 100 || got > exp + 100) begin
      err_count++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  // one conversion; expected length built from phase tick counts
  task automatic scan(input logic [3:0] sel, input int res, acq, keep);
    int n, t;
    logic saw;
    logic [31:0] q;
    logic e;
    n = 0;
    saw = 1'b0;
    t = 10 + (acq == 0 ? 15 : 50) + 9 + 2 * res;
    if (sel >= 3 && keep == 0) begin
      t = t + 100 + 50 * res;
    end
    adc_data <= 12'($random(seed));
    wr(8'h00, {21'h0, 2'(acq), 2'(res), 1'b0, 1'(keep), 1'b0, sel});
    while (busy_n !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (busy_n === 1'b0 && n < 30000) begin
      @(posedge clk);
      n++;
      saw = saw | ref_on;
    end
    #1;
    chk_near("scan length", t * 20, n);
    if (sel >= 3) chk("ref in scan", 32'h1, {31'h0, saw});
    chk("ref after scan", 32'(keep), {31'h0, ref_on});
    apb(1'b0, tak_pkg::ADR_RESULT, 32'h0, q, e);
    chk("result", {20'h0, adc_data >> (4 - 2 * res)}, q);
  endtask
  // main sequence
  initial begin
    logic [31:0] q, v;
    logic e;
    int n;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, tak_pkg::ADR_DAC, 32'h0, q, e);
    chk("dac reset", 32'h80, q);
    apb(1'b0, tak_pkg::ADR_ADC_CTRL, 32'h0, q, e);
    chk("adc ctrl reset", 32'h0, q);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(tak_pkg::ADR_DAC, v);
      apb(1'b0, tak_pkg::ADR_DAC, 32'h0, q, e);
      chk("dac read", {24'h0, v[7:0]}, q);
      chk("dac pin", {24'h0, v[7:0]}, {24'h0, dac_code});
    end
    // frozen clock enable ignores a write, then a mid-run reset
    ce <= 1'b0;
    wr(tak_pkg::ADR_DAC, ~v);
    chk("dac frozen", {24'h0, v[7:0]}, {24'h0, dac_code});
    ce <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk("dac again", 32'(tak_pkg::DAC_RESET), 32'(dac_code));
    apb(1'b0, 8'h30, 32'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    $display("test registers done");
    for (int r = 0; r < 3; r++) scan(tak_pkg::SEL_TEMP, r, 0, 0);
    scan(tak_pkg::SEL_X, 2, 0, 0);
    scan(tak_pkg::SEL_Y, 2, 1, 0);
    scan(tak_pkg::SEL_BAT1, 2, 0, 1);
    wr(tak_pkg::ADR_ADC_CTRL, 32'h50);
    chk("ref source", 32'h1, {31'h0, ref_src});
    chk("ref level", 32'h1, {31'h0, ref_lvl});
    wr(tak_pkg::ADR_ADC_CTRL, 32'h0);
    chk("ref internal", 32'h0, {30'h0, ref_src, ref_on});
    $display("test scans done");
    pressed <= 16'h0021;
    wr(tak_pkg::ADR_KEY_MASK, 32'h20);
    wr(tak_pkg::ADR_KEY_CTRL, 32'h3);
    n = 0;
    while (kirq_n !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    apb(1'b0, tak_pkg::ADR_KEY_SCAN, 32'h0, q, e);
    chk("key scan", 32'h1, q);
    apb(1'b0, tak_pkg::ADR_KEY_PEND, 32'h0, q, e);
    chk("key pending", 32'h1, q);
    chk("key irq clear", 32'h1, {31'h0, kirq_n});
    wr(tak_pkg::ADR_COL_MASK, 32'h1);
    n = 0;
    do begin
      while (busy_n !== 1'b1) @(posedge clk);
      apb(1'b0, tak_pkg::ADR_KEY_SCAN, 32'h0, q, e);
      n++;
    end while (q !== 32'h0 && n < 1000);
    chk("column masked", 32'h0, q);
    wr(tak_pkg::ADR_GPIO_SEL, 32'h1);
    wr(tak_pkg::ADR_GPIO_OUT, 32'h101);
    chk("gpio row", 32'h11, {24'h0, row_oe, row_o});
    wr(tak_pkg::ADR_KEY_CTRL, 32'h0);
    touched <= 1'b1;
    wr(tak_pkg::ADR_ADC_CTRL, 32'h800);
    repeat (5) @(posedge clk);
    chk("touch irq", 32'h0, {31'h0, tirq_n});
    chk("touch drv", 32'h3, {30'h0, pen_pu, yn});
    $display("test keypad and touch done");
    summarize();
  end
  // watchdog, about three times the expected run
  initial begin
    #300000;
    err_count++;
    summarize();
  end
endmodule
